// file: rtl/scd_params.svh
// constants for the stepper command decoder: encodings, lengths, flag positions
`ifndef SCD_PARAMS_SVH
`define SCD_PARAMS_SVH

// opcode patterns, bit 7 first, '?' marks a field bit
`define SCD_OP_NOP         8'b0000_0000
`define SCD_OP_WRITE       8'b000?_????
`define SCD_OP_READ        8'b001?_????
`define SCD_OP_RUN         8'b0101_000?
`define SCD_OP_PULSE       8'b0101_100?
`define SCD_OP_MOVE        8'b0100_000?
`define SCD_OP_SEEK        8'b0110_0000
`define SCD_OP_SEEK_DIR    8'b0110_100?
`define SCD_OP_SEEK_SW     8'b1000_?01?
`define SCD_OP_BACKOFF     8'b1001_?01?
`define SCD_OP_ORIGIN      8'b0111_0000
`define SCD_OP_MARKER      8'b0111_1000
`define SCD_OP_ZERO        8'b1101_1000
`define SCD_OP_FULLRST     8'b1100_0000
`define SCD_OP_RHALT       8'b1011_0000
`define SCD_OP_IHALT       8'b1011_1000
`define SCD_OP_RFLOAT      8'b1010_0000
`define SCD_OP_IFLOAT      8'b1010_1000
`define SCD_OP_FLAGS       8'b1101_0000

// argument and answer lengths in bytes
`define SCD_LEN_NONE       2'h0
`define SCD_LEN_WORD       2'h3
`define SCD_LEN_STATUS     2'h2

// status word positions of the two latched flags
`define SCD_BIT_UNKNOWN    8
`define SCD_BIT_NOTPERF    7

// bits per link byte, minus one
`define SCD_LAST_BIT       3'h7

`endif

// file: rtl/scd_pkg.sv
// types shared by the stepper command decoder
`default_nettype none
package scd_pkg;

  // decoded command kinds
  typedef enum logic [4:0] {
    SCD_NOP      = 5'h00,
    SCD_WRITE    = 5'h01,
    SCD_READ     = 5'h02,
    SCD_RUN      = 5'h03,
    SCD_PULSE    = 5'h04,
    SCD_MOVE     = 5'h05,
    SCD_SEEK     = 5'h06,
    SCD_SEEK_DIR = 5'h07,
    SCD_SEEK_SW  = 5'h08,
    SCD_BACKOFF  = 5'h09,
    SCD_ORIGIN   = 5'h0A,
    SCD_MARKER   = 5'h0B,
    SCD_ZERO     = 5'h0C,
    SCD_FULLRST  = 5'h0D,
    SCD_RHALT    = 5'h0E,
    SCD_IHALT    = 5'h0F,
    SCD_RFLOAT   = 5'h10,
    SCD_IFLOAT   = 5'h11,
    SCD_FLAGS    = 5'h12,
    SCD_BAD      = 5'h13
  } scd_kind_t;

  // command handed to the motion core
  typedef struct packed {
    scd_kind_t   kind;
    logic        dir;
    logic        act;
    logic [4:0]  addr;
    logic [23:0] arg;
  } scd_cmd_t;

  // register attributes answered by the register map
  typedef struct packed {
    logic       exists;
    logic       writable;
    logic       condWrite;
    logic [1:0] len;
  } scd_reg_info_t;

endpackage

`default_nettype wire

// file: rtl/scd_command_decoder.sv
// stepper command decoder: byte link, opcode dispatch, answers and flags
`timescale 1ns/1ps
`default_nettype none
`include "scd_params.svh"

module scd_command_decoder (
  input  wire logic                   clock,
  input  wire logic                   reset,
  input  wire logic                   linkClk,
  input  wire logic                   csN,
  input  wire logic                   mosiIn,
  output logic                        misoOut,
  output logic                        misoOe,
  output logic [4:0]                  regSelect,
  input  wire scd_pkg::scd_reg_info_t regInfo,
  input  wire logic [23:0]            regValue,
  input  wire logic                   regCondOk,
  input  wire logic                   motorRunning,
  input  wire logic [15:0]            statusIn,
  output logic                        cmdValid,
  output scd_pkg::scd_cmd_t           cmd,
  output logic                        unknownFlag,
  output logic                        notPerfFlag
);
  import scd_pkg::*;

  // ---------------------------------------------------------------
  // opcode classification and argument lengths
  // ---------------------------------------------------------------
  // defined opcodes mapped to kinds; anything else is undefined
  function automatic scd_kind_t classify(input logic [7:0] op);
    scd_kind_t k;
    k = SCD_BAD;
    casez (op)
      // write opcodes; address zero is the no-op
      `SCD_OP_NOP:      k = SCD_NOP;
      `SCD_OP_WRITE:    k = SCD_WRITE;
      `SCD_OP_READ:     k = SCD_READ;
      `SCD_OP_RUN:      k = SCD_RUN;
      `SCD_OP_PULSE:    k = SCD_PULSE;
      `SCD_OP_MOVE:     k = SCD_MOVE;
      `SCD_OP_SEEK:     k = SCD_SEEK;
      `SCD_OP_SEEK_DIR: k = SCD_SEEK_DIR;
      `SCD_OP_SEEK_SW:  k = SCD_SEEK_SW;
      `SCD_OP_BACKOFF:  k = SCD_BACKOFF;
      `SCD_OP_ORIGIN:   k = SCD_ORIGIN;
      `SCD_OP_MARKER:   k = SCD_MARKER;
      `SCD_OP_ZERO:     k = SCD_ZERO;
      `SCD_OP_FULLRST:  k = SCD_FULLRST;
      `SCD_OP_RHALT:    k = SCD_RHALT;
      `SCD_OP_IHALT:    k = SCD_IHALT;
      `SCD_OP_RFLOAT:   k = SCD_RFLOAT;
      `SCD_OP_IFLOAT:   k = SCD_IFLOAT;
      `SCD_OP_FLAGS:    k = SCD_FLAGS;
      default:          k = SCD_BAD;
    endcase
    return k;
  endfunction

  // fixed argument counts; writes take the register length instead
  function automatic logic [1:0] argCount(input scd_kind_t k);
    logic [1:0] n;
    n = `SCD_LEN_NONE;
    // run, move, seek, seek-dir and seek-sw carry three argument bytes; pulse and backoff carry none
    if (k == SCD_RUN || k == SCD_MOVE || k == SCD_SEEK ||
        k == SCD_SEEK_DIR || k == SCD_SEEK_SW) begin
      n = `SCD_LEN_WORD;
    end
    return n;
  endfunction

  // ---------------------------------------------------------------
  // link domain: reset crossing, shifter, answer output
  // ---------------------------------------------------------------
  logic       linkRstA_r;
  logic       linkRstB_r;
  logic       linkRstC_r;
  logic       linkRst_r;  // agreed reset level, link domain
  logic [2:0] bitCnt_r;
  logic [6:0] rxShift_r;
  logic [7:0] rxByte_r;
  logic       rxTog_r;
  logic [7:0] txShift_r;
  logic [7:0] txByte_r;   // core domain, stable between bytes

  // reset level carried into the link domain by three flops;
  // a change counts only once the second and third agree
  always_ff @(posedge linkClk) begin
    linkRstA_r <= reset;
    linkRstB_r <= linkRstA_r;
    linkRstC_r <= linkRstB_r;
    if (linkRstB_r == linkRstC_r) begin
      linkRst_r <= linkRstC_r;
    end
  end

  // bits sampled on the rising edge while selected; byte ends at bit 7
  always_ff @(posedge linkClk) begin
    if (linkRst_r) begin
      bitCnt_r  <= 3'h0;
      rxShift_r <= 7'h00;
      rxByte_r  <= 8'h00;
      rxTog_r   <= 1'b0;
    end else if (!csN) begin
      bitCnt_r  <= bitCnt_r + 3'h1;
      rxShift_r <= {rxShift_r[5:0], mosiIn};
      if (bitCnt_r == `SCD_LAST_BIT) begin
        rxByte_r <= {rxShift_r, mosiIn};
        rxTog_r  <= ~rxTog_r;   // toggle survives any clock ratio
      end
    end
  end

  // answer byte is taken whole at the first bit of each byte
  always_ff @(posedge linkClk) begin
    if (linkRst_r) begin
      txShift_r <= 8'h00;
    end else if (!csN) begin
      if (bitCnt_r == 3'h0) begin
        txShift_r <= {txByte_r[6:0], 1'b0};
      end else begin
        txShift_r <= {txShift_r[6:0], 1'b0};
      end
    end
  end

  // first bit comes straight from the held byte, later ones shift
  assign misoOut = (bitCnt_r == 3'h0) ? txByte_r[7] : txShift_r[7];
  assign misoOe  = !csN;

  // ---------------------------------------------------------------
  // core domain: byte event crossing
  // ---------------------------------------------------------------
  logic       togA_r;
  logic       togB_r;
  logic       togC_r;
  logic       togSeen_r;
  logic       byteEvt;
  logic [7:0] byteIn;

  // three flops; a toggle counts once second and third agree
  always_ff @(posedge clock) begin
    if (reset) begin
      togA_r    <= 1'b0;
      togB_r    <= 1'b0;
      togC_r    <= 1'b0;
      togSeen_r <= 1'b0;
    end else begin
      togA_r    <= rxTog_r;
      togB_r    <= togA_r;
      togC_r    <= togB_r;
      if (togB_r == togC_r) begin
        togSeen_r <= togC_r;
      end
    end
  end

  assign byteEvt = (togB_r == togC_r) && (togC_r != togSeen_r);
  assign byteIn  = rxByte_r;   // held stable since the toggle

  // ---------------------------------------------------------------
  // decode and dispatch
  // ---------------------------------------------------------------
  logic [1:0]  argsLeft_r;
  scd_kind_t   curKind_r;
  logic [7:0]  curOp_r;
  logic [23:0] argAcc_r;
  logic [23:0] respBuf_r;
  logic [1:0]  respLeft_r;
  logic        unknownFlag_r;
  logic        notPerfFlag_r;
  logic        cmdValid_r;
  scd_cmd_t    cmd_r;
  scd_kind_t   opKind;
  logic        isOpcode;
  logic        lastArg;
  logic [23:0] argNext;
  logic        setUnknown;
  logic        setNotPerf;
  logic        clrFlags;
  logic        refuse;
  logic [15:0] statusWord;
  logic [23:0] readWord;

  // countdown zero means this byte is an opcode
  assign isOpcode = (argsLeft_r == 2'h0);
  assign lastArg  = (argsLeft_r == 2'h1);
  assign opKind   = classify(byteIn);
  // arguments shift in most significant byte first
  assign argNext  = {argAcc_r[15:0], byteIn};
  // address query follows the opcode, then the held one
  assign regSelect = isOpcode ? byteIn[4:0] : curOp_r[4:0];

  // conditional write, or move while the motor runs, refused at the final argument
  assign refuse = (curKind_r == SCD_MOVE && motorRunning) ||
                  (curKind_r == SCD_WRITE && regInfo.condWrite &&
                   !regCondOk);

  // undefined bytes raise the unknown flag
  // read-only target flagged at the opcode byte
  // missing write target flagged at the opcode
  // missing read target flagged at the opcode
  assign setUnknown = byteEvt && isOpcode &&
    (opKind == SCD_BAD ||
     (opKind == SCD_WRITE && !(regInfo.exists && regInfo.writable)) ||
     (opKind == SCD_READ && !regInfo.exists));
  assign setNotPerf = byteEvt && lastArg && refuse;
  assign clrFlags   = byteEvt && isOpcode &&
                      (opKind == SCD_FLAGS || opKind == SCD_FULLRST);

  // status word with the two latched flags spliced in
  always_comb begin
    statusWord = statusIn;
    statusWord[`SCD_BIT_UNKNOWN] = unknownFlag_r;
    statusWord[`SCD_BIT_NOTPERF] = notPerfFlag_r;
  end

  // register value left aligned by its length
  always_comb begin
    unique case (regInfo.len)
      2'h1:    readWord = {regValue[7:0], 16'h0000};
      2'h2:    readWord = {regValue[15:0], 8'h00};
      default: readWord = regValue;
    endcase
  end

  // latched flags; a new set beats the status read clear
  always_ff @(posedge clock) begin
    if (reset) begin
      unknownFlag_r <= 1'b0;
      notPerfFlag_r <= 1'b0;
    end else begin
      unknownFlag_r <= setUnknown || (unknownFlag_r && !clrFlags);
      notPerfFlag_r <= setNotPerf || (notPerfFlag_r && !clrFlags);
    end
  end

  // argument countdown and command capture
  always_ff @(posedge clock) begin
    if (reset) begin
      argsLeft_r <= 2'h0;
      curKind_r  <= SCD_NOP;
      curOp_r    <= 8'h00;
      argAcc_r   <= 24'h000000;
    end else if (byteEvt) begin
      if (isOpcode) begin
        curKind_r <= opKind;
        curOp_r   <= byteIn;
        argAcc_r  <= 24'h000000;
        // a bad write still swallows no arguments
        if (opKind == SCD_WRITE && !setUnknown) begin
          argsLeft_r <= regInfo.len;
        end else begin
          argsLeft_r <= argCount(opKind);
        end
      end else begin
        argsLeft_r <= argsLeft_r - 2'h1;
        argAcc_r   <= argNext;
      end
    end
  end

  // one-cycle command pulse, issued when the last byte lands
  always_ff @(posedge clock) begin
    if (reset) begin
      cmdValid_r <= 1'b0;
      cmd_r      <= '0;
    end else begin
      cmdValid_r <= 1'b0;
      if (byteEvt && isOpcode && opKind != SCD_BAD &&
          opKind != SCD_NOP && !setUnknown &&
          argCount(opKind) == `SCD_LEN_NONE && opKind != SCD_WRITE) begin
        // argument-free commands go out at once
        cmdValid_r <= 1'b1;
        cmd_r.kind <= opKind;
        cmd_r.dir  <= byteIn[0];
        cmd_r.act  <= byteIn[3];
        cmd_r.addr <= byteIn[4:0];
        cmd_r.arg  <= 24'h000000;
      end else if (byteEvt && lastArg && !refuse) begin
        cmdValid_r <= 1'b1;
        cmd_r.kind <= curKind_r;
        cmd_r.dir  <= curOp_r[0];
        cmd_r.act  <= curOp_r[3];
        cmd_r.addr <= curOp_r[4:0];
        cmd_r.arg  <= argNext;
      end
    end
  end

  // ---------------------------------------------------------------
  // answer buffer
  // ---------------------------------------------------------------
  // zeros unless an answer is pending
  // a new answering opcode replaces any pending answer
  always_ff @(posedge clock) begin
    if (reset) begin
      txByte_r   <= 8'h00;
      respBuf_r  <= 24'h000000;
      respLeft_r <= 2'h0;
    end else if (byteEvt) begin
      if (isOpcode && opKind == SCD_READ && !setUnknown) begin
        txByte_r   <= readWord[23:16];
        respBuf_r  <= {readWord[15:0], 8'h00};
        respLeft_r <= regInfo.len - 2'h1;
      end else if (isOpcode && opKind == SCD_FLAGS) begin
        // status word, flags as they stood before clearing
        txByte_r   <= statusWord[15:8];
        respBuf_r  <= {statusWord[7:0], 16'h0000};
        respLeft_r <= `SCD_LEN_STATUS - 2'h1;
      end else if (isOpcode && opKind == SCD_FULLRST) begin
        txByte_r   <= 8'h00;
        respBuf_r  <= 24'h000000;
        respLeft_r <= 2'h0;
      end else if (respLeft_r != 2'h0) begin
        txByte_r   <= respBuf_r[23:16];
        respBuf_r  <= {respBuf_r[15:0], 8'h00};
        respLeft_r <= respLeft_r - 2'h1;
      end else begin
        txByte_r   <= 8'h00;
      end
    end
  end

  // ---------------------------------------------------------------
  // outputs
  // ---------------------------------------------------------------
  assign cmdValid    = cmdValid_r;
  assign cmd         = cmd_r;
  assign unknownFlag = unknownFlag_r;
  assign notPerfFlag = notPerfFlag_r;

endmodule

`default_nettype wire

// file: verif/scd_command_decoder_sva.sv
// port checker for the stepper command decoder
`timescale 1ns/1ps
`default_nettype none
module scd_command_decoder_sva
  import scd_pkg::*;
(
  input wire logic              clock,
  input wire logic              reset,
  input wire logic              csN,
  input wire logic              misoOe,
  input wire logic              motorRunning,
  input wire logic              cmdValid,
  input wire scd_pkg::scd_cmd_t cmd,
  input wire logic              unknownFlag,
  input wire logic              notPerfFlag
);
  // ----------------------------------------
  // helpers and sequences
  // ----------------------------------------
  default clocking cb @(posedge clock); endclocking
  default disable iff (reset);
  logic clrCmd;
  // either flag may only drop around a flag read or a full reset
  assign clrCmd = cmdValid &&
                  (cmd.kind == SCD_FLAGS || cmd.kind == SCD_FULLRST);
  sequence s_quiet2;
    !cmdValid ##1 !cmdValid;
  endsequence
  sequence s_clear_near;
    ##[0:2] clrCmd;
  endsequence

  a_pulse_one_cycle: assert property (cmdValid |=> !cmdValid)
    else $error("command pulse longer than one cycle");
  a_cmd_holds_between: assert property (!cmdValid |-> $stable(cmd))
    else $error("command changed without a pulse");
  a_oe_tracks_select: assert property (misoOe == !csN)
    else $error("output enable does not follow chip select");
  a_unknown_stays_latched: assert property (
    $fell(unknownFlag) |-> s_clear_near or $past(clrCmd))
    else $error("unknown flag dropped without a flag read");
  a_notperf_stays_latched: assert property (
    $fell(notPerfFlag) |-> s_clear_near or $past(clrCmd))
    else $error("not-performable flag dropped without a flag read");
  a_unknown_no_cmd: assert property ($rose(unknownFlag) |-> s_quiet2)
    else $error("command issued for an undefined byte");
  a_notperf_no_cmd: assert property ($rose(notPerfFlag) |-> s_quiet2)
    else $error("command issued for a refused request");
  a_move_only_idle: assert property (
    cmdValid && cmd.kind == SCD_MOVE |-> !$past(motorRunning))
    else $error("move issued while motor running");
  a_kind_defined: assert property (
    cmdValid |-> cmd.kind != SCD_BAD && cmd.kind != SCD_NOP)
    else $error("pulse carries no valid command kind");
endmodule
bind scd_command_decoder scd_command_decoder_sva chk_u (
  .clock(clock), .reset(reset), .csN(csN), .misoOe(misoOe),
  .motorRunning(motorRunning), .cmdValid(cmdValid), .cmd(cmd),
  .unknownFlag(unknownFlag), .notPerfFlag(notPerfFlag));
`default_nettype wire

// file: verif/scd_host_model.sv
// host-side link model that frames bytes on the serial link
`timescale 1ns/1ps
`default_nettype none
module scd_host_model (
  output logic     linkClk,
  output logic     csN,
  output logic     mosiIn,
  input wire logic misoOut
);
  // ----------------------------------------
  // link driver
  // ----------------------------------------
  // idle: clock low, deselected
  initial begin
    linkClk = 1'b0;
    csN = 1'b1;
    mosiIn = 1'b0;
  end
  // deselected edges so the link side sees reset
  task automatic idle_edges(input int n);
    repeat (n) begin
      #62.5 linkClk = 1'b1;
      #62.5 linkClk = 1'b0;
    end
  endtask
  // caller orders value bytes top first
  task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
    #7 csN = 1'b0;
    for (int i = 7; i >= 0; i--) begin
      mosiIn = tx[i];
      #62.5 rx[i] = misoOut; // read before the edge moves it
      linkClk = 1'b1;
      #62.5 linkClk = 1'b0;
    end
    mosiIn = ~mosiIn; // released line shows no stale bit
    #10 csN = 1'b1;
    #600; // core gets 12 clocks to take the byte
  endtask
endmodule
`default_nettype wire

// file: verif/stepper_command_decoder_bench.sv
// self-checking bench for the stepper command decoder
`timescale 1ns/1ps
`default_nettype none
module stepper_command_decoder_bench;
  import scd_pkg::*;
  logic          clock = 1'b0;
  logic          reset = 1'b1;
  logic          regCondOk = 1'b1;
  logic          motorRunning = 1'b0;
  logic [15:0]   statusIn = 16'h3C66;
  logic          linkClk, csN, mosiIn, misoOut, misoOe, cmdValid;
  logic          unknownFlag, notPerfFlag;
  logic [4:0]    regSelect;
  logic [23:0]   regValue;
  logic [7:0]    rx;
  scd_reg_info_t regInfo;
  scd_cmd_t      cmd, lastCmd;
  int            n_fail = 0;
  int            n_tests = 0;
  int            nCmd = 0;

  // ----------------------------------------
  // environment
  // ----------------------------------------
  always #25 clock = ~clock;
  function automatic logic [23:0] rval(input logic [4:0] a);
    return {3'h0, a, 8'hC3, 3'h0, a};
  endfunction
  // map stand-in: 1 len3, 2 read-only len2, 3 conditional len1
  always_comb begin
    regInfo = '{1'b0, 1'b0, 1'b0, 2'h1};
    case (regSelect)
      5'h01: regInfo = '{1'b1, 1'b1, 1'b0, 2'h3};
      5'h02: regInfo = '{1'b1, 1'b0, 1'b0, 2'h2};
      5'h03: regInfo = '{1'b1, 1'b1, 1'b1, 2'h1};
      default: ;
    endcase
  end
  assign regValue = rval(regSelect);
  // command monitor
  always @(posedge clock) begin
    if (cmdValid === 1'b1) begin
      nCmd <= nCmd + 1;
      lastCmd <= cmd;
    end
  end
  scd_host_model host_u (.linkClk(linkClk), .csN(csN), .mosiIn(mosiIn),
                         .misoOut(misoOut));
  scd_command_decoder dut_u (.clock(clock), .reset(reset),
    .linkClk(linkClk), .csN(csN), .mosiIn(mosiIn), .misoOut(misoOut),
    .misoOe(misoOe), .regSelect(regSelect), .regInfo(regInfo),
    .regValue(regValue), .regCondOk(regCondOk),
    .motorRunning(motorRunning), .statusIn(statusIn),
    .cmdValid(cmdValid), .cmd(cmd), .unknownFlag(unknownFlag),
    .notPerfFlag(notPerfFlag));

  // ----------------------------------------
  // shared tasks
  // ----------------------------------------
  task automatic chk(input logic [23:0] seen, input logic [23:0] exp);
    n_tests++;
    if (seen !== exp) begin
      n_fail++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic xb(input logic [7:0] b);
    host_u.xfer(b, rx);
  endtask
  task automatic cmd_is(input int n0, input scd_kind_t k,
                        input logic [7:0] op, input logic [23:0] arg);
    chk(24'(nCmd - n0), 24'h1);
    chk(24'(lastCmd.kind), 24'(k));
    chk({22'h0, lastCmd.dir, lastCmd.act}, {22'h0, op[0], op[3]});
    chk(lastCmd.arg, arg);
  endtask
  task automatic flags_read(input logic [7:0] hi, input logic [7:0] lo);
    xb(8'hD0);
    xb(8'h00);
    chk(24'(rx), 24'(hi));
    xb(8'h00);
    chk(24'(rx), 24'(lo));
    chk({22'h0, unknownFlag, notPerfFlag}, 24'h0);
  endtask

  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_no_arg();
    logic [7:0] ops [9];
    scd_kind_t  ks [9];
    int         n0;
    ops = '{8'h70, 8'h78, 8'hD8, 8'hB0, 8'hB8, 8'hA0, 8'hA8, 8'h59, 8'h9B};
    ks = '{SCD_ORIGIN, SCD_MARKER, SCD_ZERO, SCD_RHALT, SCD_IHALT,
           SCD_RFLOAT, SCD_IFLOAT, SCD_PULSE, SCD_BACKOFF};
    for (int i = 0; i < 9; i++) begin
      n0 = nCmd;
      xb(ops[i]);
      cmd_is(n0, ks[i], ops[i], 24'h0);
      chk(24'(rx), 24'h0);
    end
    n0 = nCmd;
    xb(8'h00);
    chk(24'(nCmd - n0), 24'h0);
  endtask
  task automatic t_args();
    logic [7:0] ops [5];
    scd_kind_t  ks [5];
    int         n0;
    ops = '{8'h51, 8'h41, 8'h60, 8'h69, 8'h8B};
    ks = '{SCD_RUN, SCD_MOVE, SCD_SEEK, SCD_SEEK_DIR, SCD_SEEK_SW};
    for (int i = 0; i < 5; i++) begin
      n0 = nCmd;
      xb(ops[i]);
      xb(8'h12);
      xb(8'h34);
      chk(24'(nCmd - n0), 24'h0);
      xb(8'h56);
      cmd_is(n0, ks[i], ops[i], 24'h123456);
    end
    n0 = nCmd;
    xb(8'h01);
    xb(8'hAB);
    xb(8'hCD);
    xb(8'hEF);
    cmd_is(n0, SCD_WRITE, 8'h01, 24'hABCDEF);
    n0 = nCmd;
    xb(8'h03);
    xb(8'h5A);
    cmd_is(n0, SCD_WRITE, 8'h03, 24'h00005A);
    chk(24'(lastCmd.addr), 24'h3);
  endtask
  task automatic t_read();
    xb(8'h22);
    xb(8'h00);
    chk(24'(rx), 24'hC3);
    xb(8'h00);
    chk(24'(rx), 24'h02);
    xb(8'h00);
    chk(24'(rx), 24'h00);
    xb(8'h21);
    xb(8'h22); // aborts the three-byte answer
    chk(24'(rx), 24'h01);
    xb(8'h00);
    chk(24'(rx), 24'hC3);
    xb(8'h00);
    chk(24'(rx), 24'h02);
    xb(8'h23);
    xb(8'h00);
    chk(24'(rx), 24'h03);
    xb(8'h00);
    chk(24'(rx), 24'h00);
  endtask
  task automatic t_refuse();
    logic [7:0] bad [4];
    int         n0;
    bad = '{8'hEB, 8'h02, 8'h1F, 8'h3F};
    for (int i = 0; i < 4; i++) begin
      n0 = nCmd;
      xb(bad[i]);
      chk(24'(unknownFlag), 24'h1);
      flags_read(8'h3D, 8'h66);
      chk(24'(nCmd - n0), 24'h1);
    end
    @(negedge clock) motorRunning = 1'b1;
    n0 = nCmd;
    xb(8'h41);
    xb(8'h01);
    xb(8'h02);
    chk(24'(notPerfFlag), 24'h0);
    xb(8'h03);
    chk({23'h0, notPerfFlag}, 24'h1);
    chk(24'(nCmd - n0), 24'h0);
    @(negedge clock) motorRunning = 1'b0;
    flags_read(8'h3C, 8'hE6);
    @(negedge clock) regCondOk = 1'b0;
    n0 = nCmd;
    xb(8'h03);
    chk(24'(notPerfFlag), 24'h0);
    xb(8'h77);
    chk(24'(notPerfFlag), 24'h1);
    chk(24'(nCmd - n0), 24'h0);
    @(negedge clock) regCondOk = 1'b1;
    xb(8'hEB);
    n0 = nCmd;
    xb(8'hC0);
    cmd_is(n0, SCD_FULLRST, 8'hC0, 24'h0);
    chk({22'h0, unknownFlag, notPerfFlag}, 24'h0);
  endtask

  task automatic report_and_stop();
    $display("comparisons %0d mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  // link reset needs 4 deselected edges to take hold, 4 more to leave
  initial begin
    fork
      host_u.idle_edges(5);
      repeat (2) @(negedge clock);
    join
    @(negedge clock) reset = 1'b0;
    host_u.idle_edges(4);
    repeat (4) @(negedge clock);
    t_no_arg();
    t_args();
    t_read();
    t_refuse();
    report_and_stop();
  end
  // watchdog well past the expected run of about 120 us
  initial begin
    #400us;
    n_fail++;
    report_and_stop();
  end
endmodule
`default_nettype wire
